/* rtl/gsr_pkg.sv */
// shared constants and types of the gauge status readout
package gsr_pkg;
  localparam int WORD_W = 16;
  localparam int ACC_W = 15;
  localparam int CNT_W = 4;
  localparam int NGAUGE = 2;
  // status select field: top bit picks device status, next bit accumulator
  localparam int SEL_W = 4;
  localparam int SEL_TOP = 3;
  localparam int SEL_NEXT = 2;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  // incoming command layout
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 13;
  localparam logic [2:0] CMD_ENCFG = 3'h0;
  localparam int SELF_HI = 11;
  localparam int SELF_LO = 8;
  localparam int ENB0_BIT = 0;
  localparam int ENB1_BIT = 1;
  // device status word fields
  localparam int B_G1_HEADING_OUT = 15;
  localparam int B_G0_HEADING_OUT = 14;
  localparam int B_ZS1 = 13;
  localparam int B_ZS0 = 12;
  localparam int B_G1_OFF_TARGET = 11;
  localparam int B_G0_OFF_TARGET = 10;
  localparam int B_OV = 9;
  localparam int B_UV = 8;
  localparam int B_CAL = 7;
  localparam int B_SUPPLY_FAULT_ANY = 6;
  localparam int B_G1_POSITION_CHANGED = 5;
  localparam int B_G0_POSITION_CHANGED = 4;
  localparam int B_G1_HOMING_ACTIVE = 3;
  localparam int B_G0_HOMING_ACTIVE = 2;
  localparam int B_OT1 = 1;
  localparam int B_OT0 = 0;
  // accumulator word fields
  localparam int B_HOMING = 15;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [ACC_W-1:0] ACC_RESET = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    GSR_KIND_DEV = 2'b00,
    GSR_KIND_ACC = 2'b01,
    GSR_KIND_EXT = 2'b10
  } gsr_kind_t;

  typedef enum logic {
    GSR_ST_IDLE = 1'b0,
    GSR_ST_FRAME = 1'b1
  } gsr_state_t;
endpackage

/* rtl/gsr_status_readout.sv */
// status word builder and serial shifter of the dual gauge driver
`timescale 1ns/1ps

//
// Behaviour
// - Select top bit zero gives device status
// - Bits 15,14: gauge direction, one away
// - Bits 13,12: zero side, one clockwise
// - Bits 11,10: one when off target
// - Overvoltage flag sticky until reported
// - Overvoltage disables all coil drivers
// - Undervoltage only flags, no disable
// - Bit 7 shows clock calibration out of range
// - Bit 6 is OR of supply faults
// - Bits 5,4: position changed since last command
// - Homing bits clear after zero and message
// - Overtemperature flags, disables gauge until re-enable
// - Select 10 gives accumulator status word
// - Accumulator bit 15 shows any gauge homing
// - Bits 14:0 carry signed back-EMF integral
// - Accumulator cleared at reset release
// - Accumulator keeps last result after homing
// - Chip select fall loads word, MSB first
// - Accept frame only at nonzero multiple of 16
// - Invalid frame leaves fault flags latched
// - Status select persists until valid rewrite
module gsr_status_readout
  import gsr_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // gauge state from the motion logic, same clock
  input wire logic [NGAUGE-1:0] g_heading,
  input wire logic [NGAUGE-1:0] g_zero_side,
  input wire logic [NGAUGE-1:0] g_off_target,
  input wire logic [NGAUGE-1:0] g_position_step,
  input wire logic [NGAUGE-1:0] homing_start,
  input wire logic [NGAUGE-1:0] homing_stop,
  input wire logic [NGAUGE-1:0] zero_found,
  input wire logic [ACC_W-1:0] backemf_in,
  input wire logic backemf_update,
  input wire logic [WORD_W-1:0] ext_status_word,
  // fault sources, same clock
  input wire logic ov_event,
  input wire logic uv_event,
  input wire logic [NGAUGE-1:0] ot_event,
  input wire logic cal_out_of_range,
  // received frame
  output logic [WORD_W-1:0] rx_word,
  output logic rx_valid,
  // driver control
  output logic coil_drive_off,
  output logic [NGAUGE-1:0] gauge_disable
);

  function automatic gsr_kind_t kind_of(input logic [SEL_W-1:0] sel);
    if (!sel[SEL_TOP])
      return GSR_KIND_DEV;
    else if (!sel[SEL_NEXT])
      return GSR_KIND_ACC;
    else
      return GSR_KIND_EXT;
  endfunction

  // pin synchronisers; stage 1 is read only by stage 2
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic si_s1_r, si_s2_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      si_s1_r <= 1'b0;
      si_s2_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sck_s1_r <= sclk;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      si_s1_r <= si;
      si_s2_r <= si_s1_r;
    end
  end
  logic cs_fall, cs_rise, sck_rise, sck_fall;
  assign cs_fall = cs_s3_r && !cs_s2_r;
  assign cs_rise = !cs_s3_r && cs_s2_r;
  assign sck_rise = !sck_s3_r && sck_s2_r;
  assign sck_fall = sck_s3_r && !sck_s2_r;
  // status state
  logic [SEL_W-1:0] sel_r;
  logic supply_high_r, supply_low_r;
  logic [NGAUGE-1:0] changed_r, homing_r, zero_seen_r, overheat_r;
  logic coil_off_r;
  logic [ACC_W-1:0] acc_r;
  logic homing_any;
  logic [WORD_W-1:0] dev_word, acc_word, load_word;
  assign homing_any = |homing_r;
  always_comb
  begin
    dev_word = WORD_ZERO;
    dev_word[B_G1_HEADING_OUT] = g_heading[1];
    dev_word[B_G0_HEADING_OUT] = g_heading[0];
    dev_word[B_ZS1] = g_zero_side[1];
    dev_word[B_ZS0] = g_zero_side[0];
    dev_word[B_G1_OFF_TARGET] = g_off_target[1];
    dev_word[B_G0_OFF_TARGET] = g_off_target[0];
    dev_word[B_OV] = supply_high_r;
    dev_word[B_UV] = supply_low_r;
    dev_word[B_CAL] = cal_out_of_range;
    dev_word[B_SUPPLY_FAULT_ANY] = supply_high_r | supply_low_r;
    dev_word[B_G1_POSITION_CHANGED] = changed_r[1];
    dev_word[B_G0_POSITION_CHANGED] = changed_r[0];
    dev_word[B_G1_HOMING_ACTIVE] = homing_r[1];
    dev_word[B_G0_HOMING_ACTIVE] = homing_r[0];
    dev_word[B_OT1] = overheat_r[1];
    dev_word[B_OT0] = overheat_r[0];
  end

  assign acc_word = {homing_any, acc_r};

  always_comb
  begin
    case (kind_of(sel_r))
      GSR_KIND_DEV: load_word = dev_word;
      GSR_KIND_ACC: load_word = acc_word;
      default: load_word = ext_status_word;
    endcase
  end
  // frame control and shifter
  gsr_state_t state_r;
  logic [WORD_W-1:0] shift_r;
  logic so_r;
  logic [CNT_W-1:0] cnt_r;
  logic any_bit_r, dev_sent_r;
  logic frame_end, frame_ok;
  assign frame_end = (state_r == GSR_ST_FRAME) && cs_rise;
  assign frame_ok = frame_end && any_bit_r && (cnt_r == CNT_ZERO);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_r <= GSR_ST_IDLE;
    else
    begin
      case (state_r)
        GSR_ST_IDLE:
          if (cs_fall)
            state_r <= GSR_ST_FRAME;
        GSR_ST_FRAME:
          if (cs_rise)
            state_r <= GSR_ST_IDLE;
        default: state_r <= GSR_ST_IDLE;
      endcase
    end
  end
  // shifting in at the lsb end makes bits past 16 echo the input for daisy chains
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      shift_r <= WORD_ZERO;
    else if (state_r == GSR_ST_IDLE && cs_fall)
      shift_r <= load_word;
    else if (state_r == GSR_ST_FRAME && sck_rise)
      shift_r <= {shift_r[WORD_W-2:0], si_s2_r};
  end
  // output bit changes on the falling clock so the master samples it on the rise
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      so_r <= 1'b0;
    else if (state_r == GSR_ST_IDLE && cs_fall)
      so_r <= load_word[WORD_W-1];
    else if (state_r == GSR_ST_FRAME && sck_fall)
      so_r <= shift_r[WORD_W-1];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r <= CNT_ZERO;
      any_bit_r <= 1'b0;
      dev_sent_r <= 1'b0;
    end
    else if (state_r == GSR_ST_IDLE && cs_fall)
    begin
      cnt_r <= CNT_ZERO;
      any_bit_r <= 1'b0;
      dev_sent_r <= (kind_of(sel_r) == GSR_KIND_DEV);
    end
    else if (state_r == GSR_ST_FRAME && sck_rise)
    begin
      cnt_r <= cnt_r + CNT_ONE;
      any_bit_r <= 1'b1;
    end
  end
  assign so = so_r;
  assign so_oe = (state_r == GSR_ST_FRAME);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_word <= WORD_ZERO;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= frame_ok;
      if (frame_ok)
        rx_word <= shift_r;
    end
  end
  // command decode, one cycle after the frame closes
  logic encfg_hit;
  assign encfg_hit = rx_valid && (rx_word[CMD_HI:CMD_LO] == CMD_ENCFG);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      sel_r <= SEL_RESET;
    else if (encfg_hit)
      sel_r <= rx_word[SELF_HI:SELF_LO];
  end
  logic [NGAUGE-1:0] reenable;
  assign reenable[0] = encfg_hit && rx_word[ENB0_BIT];
  assign reenable[1] = encfg_hit && rx_word[ENB1_BIT];
  // supply flags clear only after a good frame that carried the device word
  logic report_clr;
  assign report_clr = frame_ok && dev_sent_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      supply_high_r <= 1'b0;
      supply_low_r <= 1'b0;
    end
    else
    begin
      supply_high_r <= ov_event || (supply_high_r && !report_clr);
      supply_low_r <= uv_event || (supply_low_r && !report_clr);
    end
  end
  // undervoltage deliberately absent: it only flags
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      coil_off_r <= 1'b0;
    else if (ov_event)
      coil_off_r <= 1'b1;
    else if (reenable == {NGAUGE{1'b1}})
      coil_off_r <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      changed_r <= '0;
    else
      changed_r <= g_position_step | (changed_r & {NGAUGE{!frame_ok}});
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      homing_r <= '0;
      zero_seen_r <= '0;
    end
    else
    begin
      for (int g = 0; g < NGAUGE; g++)
      begin
        if (homing_start[g])
        begin
          homing_r[g] <= 1'b1;
          zero_seen_r[g] <= 1'b0;
        end
        else if (homing_stop[g] || (frame_ok && zero_seen_r[g]))
        begin
          homing_r[g] <= 1'b0;
          zero_seen_r[g] <= 1'b0;
        end
        else if (homing_r[g] && zero_found[g])
          zero_seen_r[g] <= 1'b1;
      end
    end
  end
  // an event in the re-enable cycle keeps the flag set
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      overheat_r <= '0;
    else
      overheat_r <= ot_event | (overheat_r & ~reenable);
  end
  assign coil_drive_off = coil_off_r;
  assign gauge_disable = overheat_r | {NGAUGE{coil_off_r}};
  // reset release of the pin clears it; only homing updates it, so it holds after stop
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      acc_r <= ACC_RESET;
    else if (homing_any && backemf_update)
      acc_r <= backemf_in;
  end
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_load;
    state_r == GSR_ST_IDLE && cs_fall;
  endsequence

  sequence s_bad_end;
    frame_end && !frame_ok;
  endsequence

  AST_DEV_SELECT: assert property (s_load and !sel_r[SEL_TOP] |=> shift_r == $past(dev_word))
    else $error("device word not loaded");
  AST_ACC_SELECT: assert property (s_load and sel_r[SEL_TOP] && !sel_r[SEL_NEXT]
    |=> shift_r == {$past(homing_any), $past(acc_r)})
    else $error("accumulator word not loaded");
  AST_MSB_FIRST: assert property (s_load |=> so == shift_r[WORD_W-1] && so_oe)
    else $error("msb not presented first");
  AST_OV_STICKY: assert property (ov_event |=> supply_high_r && dev_word[B_SUPPLY_FAULT_ANY])
    else $error("overvoltage not latched");
  AST_OV_OFF: assert property (ov_event |=> coil_drive_off && gauge_disable == 2'b11)
    else $error("overvoltage did not disable drivers");
  AST_UV_ONLY: assert property (uv_event && !ov_event && !coil_off_r
    |=> supply_low_r && !coil_drive_off)
    else $error("undervoltage misbehaved");
  AST_BAD_KEEP: assert property (s_bad_end and supply_high_r |=> supply_high_r && !rx_valid)
    else $error("invalid frame cleared faults");
  AST_SEL_HOLD: assert property (!encfg_hit |=> $stable(sel_r))
    else $error("select changed without command");
  AST_OT_SET: assert property (ot_event[0] |=> overheat_r[0] && gauge_disable[0])
    else $error("overheat not flagged");
  AST_MOV_SET: assert property (g_position_step[1] |=> dev_word[B_G1_POSITION_CHANGED])
    else $error("movement not flagged");
  AST_HOME_CLR: assert property (zero_seen_r[0] && frame_ok && !homing_start[0]
    |=> !homing_r[0] && !dev_word[B_G0_HOMING_ACTIVE])
    else $error("homing flag not cleared");
  AST_ACC_HOLD: assert property (!homing_any |=> $stable(acc_r))
    else $error("accumulator changed outside homing");
  AST_VALID_LEN: assert property (frame_end && any_bit_r && cnt_r != CNT_ZERO |=> !rx_valid)
    else $error("bad length accepted");

endmodule

/* tb/gsr_spi_master.sv */
// serial master model that frames words on the status readout link
`timescale 1ns/1ps
module gsr_spi_master (
  // system
  input wire logic clock,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // mode 0, msb first; low 7 and high 6 clocks, 130 ns: nearest to 125 ns on this clock
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si <= tx[31 - i];
      repeat (7) @(posedge clock);
      sclk <= 1'b1;
      // so settled long before the rise, so no race here
      rx[31 - i] = so;
      repeat (6) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (7) @(posedge clock);
    cs_n <= 1'b1;
    // released line shows the inverse, not a stale bit
    si <= ~si;
    repeat (10) @(posedge clock);
  endtask
endmodule

/* tb/gsr_status_readout_test.sv */
// self-checking bench of the gauge status readout
`timescale 1ns/1ps
module gsr_status_readout_test
  import gsr_pkg::*;
;
  logic clock;
  logic rst_n = 1'b0;
  logic [NGAUGE-1:0] g_heading = 2'b10;
  logic [NGAUGE-1:0] g_zero_side = 2'b01;
  logic [NGAUGE-1:0] g_off_target = 2'b10;
  logic cal_out_of_range = 1'b1;
  logic [ACC_W-1:0] backemf_in = 15'h0000;
  logic [WORD_W-1:0] ext_status_word = 16'h0000;
  logic [12:0] ev = 13'h0000;
  logic [NGAUGE-1:0] ot_event, g_position_step, homing_start, homing_stop, zero_found;
  logic ov_event, uv_event, backemf_update;
  logic so, so_oe, rx_valid, coil_drive_off;
  logic [WORD_W-1:0] rx_word;
  logic [NGAUGE-1:0] gauge_disable;
  wire logic cs_n, sclk, si;
  logic [31:0] r;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int nvalid = 0;
  int nexp = 0;

  // one vector carries every event pulse so a single task drives them all
  assign {ov_event, uv_event, ot_event, g_position_step, homing_start, homing_stop,
    zero_found, backemf_update} = ev;

  gsr_status_readout dut (.clock, .rst_n, .cs_n, .sclk, .si, .so, .so_oe, .g_heading,
    .g_zero_side, .g_off_target, .g_position_step, .homing_start, .homing_stop,
    .zero_found, .backemf_in, .backemf_update, .ext_status_word, .ov_event, .uv_event,
    .ot_event, .cal_out_of_range, .rx_word, .rx_valid, .coil_drive_off, .gauge_disable);

  gsr_spi_master m (.clock, .cs_n, .sclk, .si, .so);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (rx_valid === 1'b1)
      nvalid++;
    if (cycles == 20000)
    begin
      failures++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xf(input int n, input logic [31:0] tx);
    m.xfer(n, tx, r);
    if (n > 0 && n % 16 == 0)
      nexp++;
  endtask

  // a non-config command, so a read leaves the status select alone
  task automatic rd(input logic [15:0] exp);
    xf(16, 32'h20000000);
    chk(r[31:16], exp);
  endtask

  task automatic pulse(input logic [12:0] v);
    ev <= v;
    @(posedge clock);
    ev <= 13'h0000;
    repeat (3) @(posedge clock);
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    rd(16'h9880);
    chk(so_oe, 1'b0);
    pulse(13'h0800);
    chk(coil_drive_off, 1'b0);
    rd(16'h99c0);
    rd(16'h9880);
    pulse(13'h1000);
    chk({coil_drive_off, gauge_disable}, 3'h7);
    xf(8, 32'h0);
    rd(16'h9ac0);
    rd(16'h9880);
    xf(16, 32'h00030000);
    chk({coil_drive_off, gauge_disable}, 3'h0);
    pulse(13'h0200);
    chk(gauge_disable, 2'b01);
    rd(16'h9881);
    xf(16, 32'h00010000);
    chk(r[31:16], 16'h9881);
    rd(16'h9880);
    chk(gauge_disable, 2'b00);
    pulse(13'h0100);
    rd(16'h98a0);
    rd(16'h9880);
    pulse(13'h0020);
    xf(16, 32'h07000000);
    chk(r[31:16], 16'h9884);
    pulse(13'h0002);
    rd(16'h9884);
    rd(16'h9880);
    pulse(13'h0040);
    rd(16'h9888);
    pulse(13'h0010);
    rd(16'h9880);
    cal_out_of_range <= 1'b0;
    xf(16, 32'h0b000000);
    chk(r[31:16], 16'h9800);
    rd(16'h0000);
    pulse(13'h0020);
    backemf_in <= 15'h7abc;
    pulse(13'h0001);
    rd(16'hfabc);
    backemf_in <= 15'h4001;
    pulse(13'h0003);
    rd(16'hc001);
    backemf_in <= 15'h1234;
    pulse(13'h0001);
    rd(16'h4001);
    xf(24, 32'h0);
    rd(16'h4001);
    ext_status_word <= 16'h5a3c;
    xf(32, 32'h12340c00);
    chk(r[31:16], 16'h4001);
    chk(r[15:0], 16'h1234);
    chk(rx_word, 16'h0c00);
    rd(16'h5a3c);
    // mid-run reset must drop the held integral again
    rst_n <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    xf(16, 32'h08000000);
    rd(16'h0000);
    chk(nvalid[15:0], nexp[15:0]);
    stop_test;
  end
endmodule
